// file: hw/asp_pkg.sv
package asp_pkg;
  // ****************************************************
  // bus shape and register byte offsets
  // ****************************************************
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_DOFS  = 8'h04;
  localparam logic [7:0] OFS_INV   = 8'h08;
  localparam logic [7:0] OFS_ROUTE = 8'h0C;
  localparam logic [7:0] OFS_SEL   = 8'h10;
  localparam logic [7:0] OFS_PINFN = 8'h14;
  localparam logic [7:0] OFS_DIV   = 8'h18;
  localparam logic [7:0] OFS_TXL   = 8'h1C;
  localparam logic [7:0] OFS_TXR   = 8'h20;
  localparam logic [7:0] OFS_RXL   = 8'h24;
  localparam logic [7:0] OFS_RXR   = 8'h28;
  localparam logic [7:0] OFS_STAT  = 8'h2C;
  // ****************************************************
  // field positions, masks and reset values
  // ****************************************************
  localparam int CFG_FMT = 6;
  localparam int CFG_WL = 4;
  localparam int CFG_BDIR = 3;
  localparam int CFG_WDIR = 2;
  localparam int CFG_TRI = 0;
  localparam int INV_BCLK = 3;
  localparam int RT_PBSRC = 7;
  localparam int RT_PWSRC = 4;
  localparam int RT_SWSRC = 2;
  localparam int RT_LOOP = 1;
  localparam int SEL_SWPIN = 2;
  localparam int SEL_SERIAL_AUDIO_IN = 0;
  localparam int PF_GP1 = 0;
  localparam int PF_GP2 = 4;
  localparam int PF_CTL = 8;
  localparam int PF_SDO = 12;
  localparam int PF_SCLK = 16;
  localparam int PF_INPUT_ONLY_PIN_ONE = 18;
  localparam int PF_INPUT_ONLY_PIN_TWO = 20;
  localparam int PF_INPUT_ONLY_PIN_THREE = 22;
  localparam logic [7:0] MSK_CFG = 8'hFD;
  localparam logic [7:0] MSK_ROUTE = 8'hBE;
  localparam logic [7:0] MSK_SEL = 8'h1D;
  localparam logic [7:0] RST_DIV = 8'h04;
  localparam logic [23:0] RST_PINFN = 24'h001000;
  // ****************************************************
  // codes
  // ****************************************************
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h1;
  localparam logic [1:0] FMT_RJ = 2'h2;
  localparam logic [1:0] FMT_LJ = 2'h3;
  localparam logic [9:0] WL16 = 10'h010;
  localparam logic [9:0] WL20 = 10'h014;
  localparam logic [9:0] WL24 = 10'h018;
  localparam logic [9:0] WL32 = 10'h020;
  localparam logic [1:0] SRC_PLAY = 2'h0;
  localparam logic [1:0] SRC_REC = 2'h1;
  localparam logic [1:0] SRC_OTHER = 2'h2;
  localparam logic [2:0] FN_SDO_PRI = 3'h1;
  localparam logic [2:0] FN_SDO_SWO = 3'h7;
  localparam logic [3:0] FN_GP_SWO = 4'h9;
  localparam logic [3:0] FN_CTL_SWO = 4'hA;
  localparam logic [3:0] FN_GP_SIN = 4'h1;
  localparam logic [1:0] FN_SCLK_SIN = 2'h3;
  localparam logic [1:0] FN_GPI_SIN = 2'h1;
  localparam logic [2:0] SWP_GP1 = 3'h0;
  localparam logic [2:0] SWP_SCLK = 3'h1;
  localparam logic [2:0] SWP_CTL = 3'h2;
  localparam logic [2:0] SWP_SDO = 3'h3;
  localparam logic [2:0] SWP_GP2 = 3'h4;
  localparam logic [2:0] SWP_INPUT_ONLY_PIN_ONE = 3'h5;
  localparam logic [2:0] SWP_INPUT_ONLY_PIN_TWO = 3'h6;
  // synchroniser lanes
  localparam int NSY = 13;
  localparam int IX_WCLK = 0;
  localparam int IX_BCLK = 1;
  localparam int IX_SERIAL_AUDIO_IN = 2;
  localparam int IX_SSDIN = 3;
  localparam int IX_SBCLK = 4;
  localparam int IX_PLAY = 5;
  localparam int IX_REC = 6;
  localparam int IX_GP1 = 7;
  localparam int IX_GP2 = 8;
  localparam int IX_SCLK = 9;
  localparam int IX_INPUT_ONLY_PIN_ONE = 10;
  localparam int IX_INPUT_ONLY_PIN_TWO = 11;
  localparam int IX_INPUT_ONLY_PIN_THREE = 12;
  typedef struct packed {
    logic       ok;
    logic       right;
    logic [4:0] idx;
  } asp_slot_type;
endpackage

// file: hw/asp_serial_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - format field selects RJ, LJ, I2S, DSP
// - RJ: LSB lands just before word edge
// - LJ: MSB on first edge after word edge
// - I2S: MSB on second edge after edge
// - DSP: falling word clock, left then right
// - DSP: data valid on falling bit clock
// - primary or secondary host, one at once
// - direction bit makes word clock output
// - primary word clock output source select
// - direction bit makes bit clock output
// - primary bit clock output source select
// - receive data from primary or secondary
// - serial out: core data or loopback
// - secondary word clock pin selector
// - pin function drives secondary word clock
// - secondary word clock output source select
// - pin function enables secondary clock input
// - MSB first, 16/20/24/32 bit words
// - programmable data offset in bit clocks
// - bit clock inversion for any format
// - optional tri-state outside data slots
module asp_serial_port (
  // apb slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [asp_pkg::AW-1:0] paddr,
  input  wire logic [asp_pkg::DW-1:0] pwdata,
  output logic      [asp_pkg::DW-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  // primary clocks and data
  input  wire logic                   wclk_in,
  output logic                        wclk_out,
  output logic                        wclk_oe,
  input  wire logic                   bclk_in,
  output logic                        bclk_out,
  output logic                        bclk_oe,
  input  wire logic                   serial_audio_in,
  output logic                        serial_audio_out,
  output logic                        serial_audio_out_oe,
  // secondary host and rate clocks
  input  wire logic                   sec_bclk_in,
  input  wire logic                   sec_data_in,
  input  wire logic                   playback_rate_clock,
  input  wire logic                   record_rate_clock,
  // shared pins
  input  wire logic                   general_pin_one_in,
  output logic                        general_pin_one_out,
  output logic                        general_pin_one_oe,
  input  wire logic                   general_pin_two_in,
  output logic                        general_pin_two_out,
  output logic                        general_pin_two_oe,
  output logic                        ctl_dout_out,
  output logic                        ctl_dout_oe,
  input  wire logic                   ctl_sclk_in,
  input  wire logic                   input_only_pin_one,
  input  wire logic                   input_only_pin_two,
  input  wire logic                   input_only_pin_three
);
  import asp_pkg::*;

  // ****************************************************
  // register file over apb
  // ****************************************************
  logic [7:0]    cfg_q, cfg_d, dofs_q, dofs_d, route_q, route_d;
  logic [7:0]    sel_q, sel_d, div_q, div_d;
  logic          inv_q, inv_d;
  logic [23:0]   pinfn_q, pinfn_d;
  logic [DW-1:0] txl_q, txl_d, txr_q, txr_d, rxl_q, rxr_q, stat;
  logic [DW-1:0] prdata_d;
  logic          pready_d, pslverr_d;
  logic [3:0]    ridx;

  // address decode shared by read and write paths
  function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
    if (a == OFS_CFG) return 4'h0;
    else if (a == OFS_DOFS) return 4'h1;
    else if (a == OFS_INV) return 4'h2;
    else if (a == OFS_ROUTE) return 4'h3;
    else if (a == OFS_SEL) return 4'h4;
    else if (a == OFS_PINFN) return 4'h5;
    else if (a == OFS_DIV) return 4'h6;
    else if (a == OFS_TXL) return 4'h7;
    else if (a == OFS_TXR) return 4'h8;
    else if (a == OFS_RXL) return 4'h9;
    else if (a == OFS_RXR) return 4'hA;
    else if (a == OFS_STAT) return 4'hB;
    else return 4'hF;
  endfunction

  // answer is prepared in setup so access never waits
  always_comb begin
    ridx = reg_index(paddr);
    {cfg_d, dofs_d, inv_d, route_d} = {cfg_q, dofs_q, inv_q, route_q};
    {sel_d, pinfn_d, div_d} = {sel_q, pinfn_q, div_q};
    {txl_d, txr_d} = {txl_q, txr_q};
    prdata_d = prdata;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      pslverr_d = (ridx == 4'hF) || (pwrite && ridx > 4'h8);
      case (ridx)
        4'h0: prdata_d = DW'(cfg_q);
        4'h1: prdata_d = DW'(dofs_q);
        4'h2: prdata_d = DW'({inv_q, 3'h0});
        4'h3: prdata_d = DW'(route_q);
        4'h4: prdata_d = DW'(sel_q);
        4'h5: prdata_d = DW'(pinfn_q);
        4'h6: prdata_d = DW'(div_q);
        4'h7: prdata_d = txl_q;
        4'h8: prdata_d = txr_q;
        4'h9: prdata_d = rxl_q;
        4'hA: prdata_d = rxr_q;
        4'hB: prdata_d = stat;
        default: prdata_d = '0;
      endcase
    end
    if (psel && penable && pready && pwrite) begin
      case (ridx)
        4'h0: cfg_d = pwdata[7:0] & MSK_CFG;
        4'h1: dofs_d = pwdata[7:0];
        4'h2: inv_d = pwdata[INV_BCLK];
        4'h3: route_d = pwdata[7:0] & MSK_ROUTE;
        4'h4: sel_d = pwdata[7:0] & MSK_SEL;
        4'h5: pinfn_d = pwdata[23:0];
        4'h6: div_d = pwdata[7:0];
        4'h7: txl_d = pwdata;
        4'h8: txr_d = pwdata;
        default: ;
      endcase
    end
  end

  // configuration flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cfg_q, dofs_q, inv_q, route_q, sel_q} <= '0;
      pinfn_q <= RST_PINFN;
      div_q <= RST_DIV;
      {txl_q, txr_q, prdata} <= '0;
      {pready, pslverr} <= 2'h0;
    end else begin
      {cfg_q, dofs_q, inv_q, route_q, sel_q} <=
        {cfg_d, dofs_d, inv_d, route_d, sel_d};
      {pinfn_q, div_q, txl_q, txr_q} <= {pinfn_d, div_d, txl_d, txr_d};
      {prdata, pready, pslverr} <= {prdata_d, pready_d, pslverr_d};
    end
  end

  // field views
  wire logic [1:0] fmt = cfg_q[CFG_FMT+:2];
  wire logic       dsp = (fmt == FMT_DSP);
  wire logic [1:0] wlc = cfg_q[CFG_WL+:2];
  wire logic       bdir = cfg_q[CFG_BDIR];
  wire logic       wdir = cfg_q[CFG_WDIR];
  wire logic       tri_en = cfg_q[CFG_TRI];
  wire logic       loop = route_q[RT_LOOP];
  wire logic [2:0] swpin = sel_q[SEL_SWPIN+:3];
  wire logic [2:0] sdofn = pinfn_q[PF_SDO+:3];
  wire logic [3:0] gp1fn = pinfn_q[PF_GP1+:4];
  wire logic [3:0] gp2fn = pinfn_q[PF_GP2+:4];

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [NSY-1:0] raw, s1_q, s2_q, s3_q, lvl_q, lvl_d;
  assign raw = {input_only_pin_three, input_only_pin_two,
                input_only_pin_one, ctl_sclk_in, general_pin_two_in,
                general_pin_one_in, record_rate_clock,
                playback_rate_clock, sec_bclk_in, sec_data_in,
                serial_audio_in, bclk_in, wclk_in};
  // a lane moves only where stages two and three agree
  always_comb lvl_d = (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {s1_q, s2_q, s3_q, lvl_q} <= '0;
    end else begin
      {s1_q, s2_q, s3_q, lvl_q} <= {raw, s1_q, s2_q, lvl_d};
    end
  end

  // ****************************************************
  // frame engine
  // ****************************************************
  logic [8:0]   pos_q, pos_d, half_q, half_d, npos;
  logic [DW-1:0] rsh_q, rsh_d, rxl_d, rxr_d, word;
  logic         bseen_q, bseen_d, wseen_q, wseen_d, tbit_q, tbit_d;
  logic         toe_q, toe_d, ibclk_q, ibclk_d, rxbit, evt_w, rch;
  logic [7:0]   dcnt_q, dcnt_d;
  logic         bclk_now, wclk_now, beff, bpeff, smp_evt, lch_evt;
  asp_slot_type sl;

  // bit position within the slot pair, MSB first
  function automatic asp_slot_type slot_of(
      input logic [8:0] pos, input logic rc, input logic [1:0] f,
      input logic [1:0] wc, input logic [7:0] ofs,
      input logic [8:0] half);
    logic [9:0]   w, st, rel;
    asp_slot_type s;
    w = (wc == 2'h0) ? WL16 : (wc == 2'h1) ? WL20 :
        (wc == 2'h2) ? WL24 : WL32;
    if (f == FMT_RJ) begin
      st = ({1'b0, half} > w) ? {1'b0, half} - w : '0;
    end else begin
      st = {2'h0, ofs} + ((f == FMT_I2S) ? 10'h001 : 10'h000);
    end
    rel = {1'b0, pos} - st;
    s.ok = ({1'b0, pos} >= st) &&
           (rel < ((f == FMT_DSP) ? (w << 1) : w));
    s.right = (f == FMT_DSP) ? (rel >= w) : rc;
    if (f == FMT_DSP && s.right) begin
      rel = rel - w;
    end
    s.idx = 5'(w - 10'h001 - rel);
    return s;
  endfunction

  // master clocks come from the pin flops so they carry no sync lag
  always_comb begin
    bclk_now = bdir ? bclk_out : lvl_d[IX_BCLK];
    wclk_now = wdir ? wclk_out : lvl_d[IX_WCLK];
    beff = bclk_now ^ inv_q;
    bpeff = bseen_q ^ inv_q;
    smp_evt = dsp ? (bpeff & ~beff) : (~bpeff & beff);
    lch_evt = dsp ? (~bpeff & beff) : (bpeff & ~beff);
    // dsp frames start on the falling word clock only
    evt_w = dsp ? (wseen_q & ~wclk_now) : (wseen_q ^ wclk_now);
    npos = evt_w ? '0 : pos_q + 9'h001;
    rch = (fmt == FMT_I2S) ? wclk_now : ~wclk_now;
    sl = slot_of(npos, rch, fmt, wlc, dofs_q, half_q);
    rxbit = sel_q[SEL_SERIAL_AUDIO_IN] ? lvl_d[IX_SSDIN] : lvl_d[IX_SERIAL_AUDIO_IN];
    word = sl.right ? txr_q : txl_q;
    {pos_d, half_d, wseen_d, rsh_d} = {pos_q, half_q, wseen_q, rsh_q};
    {rxl_d, rxr_d, tbit_d, toe_d} = {rxl_q, rxr_q, tbit_q, toe_q};
    bseen_d = bclk_now;
    if (smp_evt) begin
      pos_d = npos;
      wseen_d = wclk_now;
      if (evt_w) begin
        half_d = pos_q + 9'h001;
      end
      if (sl.ok) begin
        rsh_d = (sl.idx == 5'(slot_of(9'h000, 1'b0, FMT_LJ, wlc,
                 8'h00, 9'h000).idx)) ? DW'(rxbit)
                : {rsh_q[DW-2:0], rxbit};
        if (sl.idx == 5'h00 && sl.right) rxr_d = rsh_d;
        if (sl.idx == 5'h00 && !sl.right) rxl_d = rsh_d;
      end
    end
    if (lch_evt) begin
      tbit_d = sl.ok & word[sl.idx];
      toe_d = sl.ok | ~tri_en;
    end
    // internal bit clock: half period of div_q+1 pclk cycles
    dcnt_d = (dcnt_q == div_q) ? 8'h00 : dcnt_q + 8'h01;
    ibclk_d = ibclk_q ^ (dcnt_q == div_q);
  end

  // engine flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pos_q, half_q, rsh_q, rxl_q, rxr_q} <= '0;
      {bseen_q, wseen_q, tbit_q, toe_q, ibclk_q} <= 5'h00;
      dcnt_q <= '0;
    end else begin
      {pos_q, half_q, rsh_q, rxl_q, rxr_q} <=
        {pos_d, half_d, rsh_d, rxl_d, rxr_d};
      {bseen_q, wseen_q, tbit_q, toe_q, ibclk_q} <=
        {bseen_d, wseen_d, tbit_d, toe_d, ibclk_d};
      dcnt_q <= dcnt_d;
    end
  end
  assign stat = DW'({half_q, pos_q, rch, wseen_q});

  // ****************************************************
  // pin routing
  // ****************************************************
  logic swin, swout, pw_d, pb_d, sdo_d, sdoe_d;
  logic g1o_d, g1e_d, g2o_d, g2e_d, cto_d, cte_d;
  always_comb begin
    // secondary word clock input, only from enabled pins
    case (swpin)
      SWP_GP1: swin = lvl_d[IX_GP1] & (gp1fn == FN_GP_SIN);
      SWP_SCLK: swin = lvl_d[IX_SCLK]
                & (pinfn_q[PF_SCLK+:2] == FN_SCLK_SIN);
      SWP_GP2: swin = lvl_d[IX_GP2] & (gp2fn == FN_GP_SIN);
      SWP_INPUT_ONLY_PIN_ONE: swin = lvl_d[IX_INPUT_ONLY_PIN_ONE]
                & (pinfn_q[PF_INPUT_ONLY_PIN_ONE+:2] == FN_GPI_SIN);
      SWP_INPUT_ONLY_PIN_TWO: swin = lvl_d[IX_INPUT_ONLY_PIN_TWO]
                & (pinfn_q[PF_INPUT_ONLY_PIN_TWO+:2] == FN_GPI_SIN);
      3'h7: swin = lvl_d[IX_INPUT_ONLY_PIN_THREE] & (pinfn_q[PF_INPUT_ONLY_PIN_THREE+:2] == FN_GPI_SIN);
      default: swin = 1'b0; // output-only pins give no input
    endcase
    case (route_q[RT_SWSRC+:2])
      SRC_REC: swout = lvl_d[IX_REC];
      SRC_OTHER: swout = wclk_now;
      default: swout = lvl_d[IX_PLAY];
    endcase
    case (route_q[RT_PWSRC+:2])
      SRC_REC: pw_d = lvl_d[IX_REC];
      SRC_OTHER: pw_d = swin;
      default: pw_d = lvl_d[IX_PLAY];
    endcase
    pb_d = route_q[RT_PBSRC] ? lvl_d[IX_SBCLK] : ibclk_d;
    g1e_d = (swpin == SWP_GP1) && (gp1fn == FN_GP_SWO);
    g2e_d = (swpin == SWP_GP2) && (gp2fn == FN_GP_SWO);
    cte_d = (swpin == SWP_CTL) && (pinfn_q[PF_CTL+:4] == FN_CTL_SWO);
    g1o_d = swout & g1e_d;
    g2o_d = swout & g2e_d;
    cto_d = swout & cte_d;
    // pin function picks core data, secondary word clock or no drive
    if (sdofn == FN_SDO_PRI) begin
      sdo_d = loop ? lvl_d[IX_SSDIN] : tbit_d;
      sdoe_d = loop | toe_d;
    end else if (sdofn == FN_SDO_SWO && swpin == SWP_SDO) begin
      sdo_d = swout;
      sdoe_d = 1'b1;
    end else begin
      sdo_d = 1'b0;
      sdoe_d = 1'b0;
    end
  end

  // pin flops; clock pin enables follow the direction bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wclk_out, wclk_oe, bclk_out, bclk_oe} <= 4'h0;
      {serial_audio_out, serial_audio_out_oe} <= 2'h0;
      {general_pin_one_out, general_pin_one_oe} <= 2'h0;
      {general_pin_two_out, general_pin_two_oe} <= 2'h0;
      {ctl_dout_out, ctl_dout_oe} <= 2'h0;
    end else begin
      {wclk_out, wclk_oe} <= {pw_d, wdir};
      {bclk_out, bclk_oe} <= {pb_d, bdir};
      {serial_audio_out, serial_audio_out_oe} <= {sdo_d, sdoe_d};
      {general_pin_one_out, general_pin_one_oe} <= {g1o_d, g1e_d};
      {general_pin_two_out, general_pin_two_oe} <= {g2o_d, g2e_d};
      {ctl_dout_out, ctl_dout_oe} <= {cto_d, cte_d};
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_lj_first;
    smp_evt && fmt == FMT_LJ && npos == 9'(dofs_q);
  endsequence
  chk_lj_msb_pos: assert property (s_lj_first |-> sl.ok &&
    sl.idx == 5'(slot_of(9'h000, 1'b0, FMT_LJ, wlc, 8'h00, 9'h000).idx))
    else $error("lj msb not at first position");
  chk_i2s_skip_one: assert property (smp_evt && fmt == FMT_I2S
    && evt_w && dofs_q == 8'h00 |-> !sl.ok)
    else $error("i2s took data on first edge");
  chk_rj_lsb_end: assert property (smp_evt && fmt == FMT_RJ
    && wlc == 2'h0 && half_q > 9'h010 && npos == half_q - 9'h001 |-> sl.ok
    && sl.idx == 5'h00) else $error("rj lsb misplaced");
  chk_dsp_fall_edge: assert property (smp_evt && dsp && !inv_q
    |-> bseen_q && !bclk_now) else $error("dsp sampled on rise");
  chk_inv_swap_edge: assert property (smp_evt && !dsp && inv_q
    |-> bseen_q && !bclk_now) else $error("inversion ignored");
  chk_wclk_dir_out: assert property (wdir [*2] |-> wclk_oe)
    else $error("word clock not driven");
  chk_bclk_dir_in: assert property (!bdir [*2] |-> !bclk_oe)
    else $error("bit clock driven as input");
  chk_sdo_tri_gap: assert property (lch_evt && !sl.ok && tri_en
    && sdofn == FN_SDO_PRI && !loop |=> !serial_audio_out_oe)
    else $error("serial out driven outside slot");
  chk_sdo_loop_back: assert property (sdofn == FN_SDO_PRI
    && loop |=> serial_audio_out == lvl_q[IX_SSDIN] && serial_audio_out_oe)
    else $error("loopback not on serial out");
  chk_gp1_sw_out: assert property (g1e_d |=> general_pin_one_oe
    && general_pin_one_out == $past(swout)) else $error("pin one idle");
  chk_rx_sel_bit: assert property (smp_evt && sl.ok
    |=> rsh_q[0] == $past(rxbit)) else $error("receive bit lost");
endmodule // asp_serial_port

// file: test/asp_host_model.sv
`timescale 1ns/100ps
module asp_host_model (
  // host link pins
  output logic wclk,
  output logic bclk,
  output logic sdata
);
  import asp_pkg::*;
  // ****************************************************
  // host framing
  // ****************************************************
  // link clock stands still low outside bursts
  initial begin
    wclk  = 1'b0;
    bclk  = 1'b0;
    sdata = 1'b0;
  end
  // one slot; launch on the edge that the device does not sample
  task automatic slot(input logic dsp, input logic w, input logic d);
    bclk  = dsp;
    wclk  = w;
    sdata = d;
    #400;
    bclk  = ~dsp;
    #400;
  endtask
  // three frames of 16-bit words in h-slot halves, then a closing edge
  task automatic burst(input logic [1:0] fmt, input logic [15:0] l,
                       input logic [15:0] r, input int h);
    logic        dsp;
    logic [31:0] wd;
    int          st;
    int          q;
    dsp = (fmt == FMT_DSP);
    // first sampled slot of the word within each half
    st = (fmt == FMT_I2S) ? 1 : (fmt == FMT_RJ) ? h - 16 : 0;
    for (int f = 0; f < 3; f++) begin
      for (int ch = 0; ch < 2; ch++) begin
        for (int k = 0; k < h; k++) begin
          q  = dsp ? ch * h + k : k - st;
          wd = dsp ? {l, r} : (ch == 1) ? {r, 16'h0} : {l, 16'h0};
          // msb first; slots before or past the word carry a toggling filler
          slot(dsp, dsp ? (ch == 1 && k == h - 1) : fmt[1] ^ (ch == 1),
               (q >= 0 && q < (dsp ? 32 : 16)) ? wd[31 - q] : ~sdata);
        end
      end
    end
    // closing word clock edge ends the last half, then the clock parks
    slot(dsp, fmt[1], ~sdata);
    bclk  = 1'b0;
    sdata = ~sdata;
  endtask
endmodule // asp_host_model

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import asp_pkg::*;
  // ****************************************************
  // bench signals
  // ****************************************************
  logic          pclk, presetn, psel, penable, pwrite, perr;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd;
  logic          pready, pslverr, wclk_out, wclk_oe, bclk_out, bclk_oe;
  logic          sao, sao_oe, gp1_out, gp1_oe, gp2_out, gp2_oe;
  logic          ctl_out, ctl_oe, h_wclk, h_bclk, h_data, play, rec, v;
  logic          use_sec, gp1_drv;
  logic [5:0]    pins;
  logic [15:0]   wl, wr;
  logic [1:0]    fmt;
  int            err_count, samples_checked;
  int            seed = 83;
  // wire levels: the device wins wherever it drives the pin
  wire logic wclk_w = wclk_oe ? wclk_out : h_wclk;
  wire logic bclk_w = bclk_oe ? bclk_out : h_bclk;
  wire logic gp1_w  = gp1_oe ? gp1_out : gp1_drv;
  wire logic gp2_w  = gp2_oe ? gp2_out : pins[2];
  wire logic pri_d  = use_sec ? pins[0] : h_data;
  wire logic sec_d  = use_sec ? h_data : pins[0];
  asp_serial_port u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wclk_in(wclk_w),
    .wclk_out(wclk_out), .wclk_oe(wclk_oe), .bclk_in(bclk_w),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .serial_audio_in(pri_d),
    .serial_audio_out(sao), .serial_audio_out_oe(sao_oe),
    .sec_bclk_in(pins[1]), .sec_data_in(sec_d),
    .playback_rate_clock(play), .record_rate_clock(rec),
    .general_pin_one_in(gp1_w), .general_pin_one_out(gp1_out),
    .general_pin_one_oe(gp1_oe), .general_pin_two_in(gp2_w),
    .general_pin_two_out(gp2_out), .general_pin_two_oe(gp2_oe),
    .ctl_dout_out(ctl_out), .ctl_dout_oe(ctl_oe), .ctl_sclk_in(pins[3]),
    .input_only_pin_one(pins[4]), .input_only_pin_two(pins[5]),
    .input_only_pin_three(pins[0]));
  asp_host_model u_host (.wclk(h_wclk), .bclk(h_bclk), .sdata(h_data));
  // ****************************************************
  // clock, noise and bench tasks
  // ****************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // unused pins toggle at random so their logic is not left idle
  always @(posedge pclk) pins <= $random(seed);
  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) err_count++;
  endtask
  task automatic chk(input logic [DW-1:0] e, input logic [DW-1:0] g,
                     input string what);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: all bursts together take about half a millisecond
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    play = 1'b0;
    rec = 1'b0;
    use_sec = 1'b0;
    gp1_drv = 1'b0;
    pins = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, a refused write and an unmapped read
    chk(32'h0, {bclk_oe, wclk_oe}, "pin enables");
    apb(1'b0, OFS_CFG, 32'h0);
    chk(32'h0, rd, "cfg");
    apb(1'b0, OFS_DIV, 32'h0);
    chk({24'h0, RST_DIV}, rd, "div");
    apb(1'b0, OFS_PINFN, 32'h0);
    chk({8'h0, RST_PINFN}, rd, "pinfn");
    apb(1'b1, OFS_RXL, $random(seed));
    chk(32'h1, perr, "rxl write error");
    apb(1'b0, OFS_RXL, 32'h0);
    chk(32'h0, rd, "rxl unchanged");
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'h1, perr, "unmapped error");
    $display("test registers done");
    // every frame format, then left-justified from the secondary host
    for (int i = 0; i < 5; i++) begin
      fmt = (i == 4) ? FMT_LJ : 2'(i);
      wl = $random(seed);
      wr = $random(seed);
      use_sec <= (i == 4);
      apb(1'b1, OFS_CFG, {24'h0, fmt, 6'h00});
      apb(1'b1, OFS_SEL, {31'h0, i == 4});
      #20;
      u_host.burst(fmt, wl, wr, 20);
      repeat (10) @(posedge pclk);
      apb(1'b0, OFS_RXL, 32'h0);
      chk({16'h0, wl}, rd, "rx left");
      apb(1'b0, OFS_RXR, 32'h0);
      chk({16'h0, wr}, rd, "rx right");
    end
    $display("test formats done");
    // driven clocks, word clock from each source, secondary word clock on pin one
    apb(1'b1, OFS_CFG, 32'h0000000C);
    apb(1'b1, OFS_PINFN, {8'h0, RST_PINFN} | {28'h0, FN_GP_SWO});
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, OFS_ROUTE, {26'h0, 2'(s), 4'h2});
      v = $random(seed);
      play <= v;
      rec  <= ~v;
      repeat (8) @(posedge pclk);
      chk(32'h3, {bclk_oe, wclk_oe}, "pin enables");
      // secondary clock is routed out on pin one here, so nothing comes in
      chk((s == 1) ? rec : (s == 0) ? play : 1'b0, wclk_out, "wclk out");
      chk({1'b1, play}, {gp1_oe, gp1_out}, "gp1 wclk");
      chk({1'b1, h_data}, {sao_oe, sao}, "loopback");
    end
    // pin one as a secondary word clock input feeding the primary pin
    apb(1'b1, OFS_PINFN, {8'h0, RST_PINFN} | {28'h0, FN_GP_SIN});
    apb(1'b1, OFS_ROUTE, {26'h0, SRC_OTHER, 4'h2});
    gp1_drv <= ~play;
    repeat (8) @(posedge pclk);
    chk({1'b0, ~play}, {gp1_oe, wclk_out}, "sec wclk in");
    $display("test routing done");
    complete_run();
  end
endmodule // tb_top
